// [verilog/mrf_cfg.svh]
// constants of the midi recording filter: register map, field positions,
// status codes, controller numbers and reset values.
// assumes the includer wants plain `define macros, nothing else.
`ifndef MRF_CFG_SVH
`define MRF_CFG_SVH

// register byte offsets, one 32-bit word each
`define MRF_ADDR_FILTER 8'h00
`define MRF_ADDR_STATUS 8'h04
`define MRF_ADDR_LOCAL 8'h08
`define MRF_ADDR_REC_CNT 8'h0c
`define MRF_ADDR_DROP_CNT 8'h10

// filter register fields: one recording enable per category
`define MRF_FLT_NOTE 0
`define MRF_FLT_POLY_AT 1
`define MRF_FLT_CTRL 2
`define MRF_FLT_PROG 3
`define MRF_FLT_CHAN_AT 4
`define MRF_FLT_BEND 5
`define MRF_FLT_MODE 6
`define MRF_FLT_TUNE 7
`define MRF_FLT_SYSEX 8
`define MRF_FLT_WIDTH 9
`define MRF_FILTER_RESET 9'h1ff
`define MRF_LOCAL_RESET 16'hffff

// status register fields
`define MRF_STAT_SWEEP 0
`define MRF_STAT_SYSEX 1

// status nibbles and system bytes
`define MRF_ST_NOTE_OFF 4'h8
`define MRF_ST_NOTE_ON 4'h9
`define MRF_ST_POLY_AT 4'ha
`define MRF_ST_CTRL 4'hb
`define MRF_ST_PROG 4'hc
`define MRF_ST_CHAN_AT 4'hd
`define MRF_ST_BEND 4'he
`define MRF_ST_SYSTEM 4'hf
`define MRF_SX_START 8'hf0
`define MRF_TIME_CODE 8'hf1
`define MRF_SONG_POS 8'hf2
`define MRF_SONG_SEL 8'hf3
`define MRF_TUNE_REQ 8'hf6
`define MRF_SX_END 8'hf7
`define MRF_REALTIME 8'hf8

// controller numbers of channel mode messages
`define MRF_CC_LAST_PLAIN 8'h77
`define MRF_CC_SOUND_OFF 8'h78
`define MRF_CC_RESET_ALL 8'h79
`define MRF_CC_LOCAL 8'h7a
`define MRF_CC_NOTES_OFF 8'h7b
`define MRF_CC_OMNI_OFF 8'h7c
`define MRF_CC_OMNI_ON 8'h7d
`define MRF_CC_MONO 8'h7e
`define MRF_CC_POLY 8'h7f
`define MRF_MONO_MAX 8'h10
`define MRF_VAL_OFF 8'h00
`define MRF_VAL_ON 8'h7f

// universal realtime sysex and the sub ids kept off the recorder
`define MRF_SX_UNIV_RT 8'h7f
`define MRF_SX_SUB_MTC 8'h01
`define MRF_SX_SUB_MMC 8'h06
`define MRF_NOTE_OFF_VEL 8'h40

`endif

// [verilog/mrf_pkg.sv]
// types shared by the midi recording filter modules.
// assumes nothing beyond a SystemVerilog compiler.
package mrf_pkg;
	typedef logic [7:0] mrf_byte_t;
	// system exclusive handling of the recording path
	typedef enum logic [3:0] {
		MRF_SX_IDLE = 4'b0001,
		MRF_SX_HOLD = 4'b0010,
		MRF_SX_PASS = 4'b0100,
		MRF_SX_DROP = 4'b1000
	} mrf_sx_state_t;
endpackage

// [verilog/mrf_parser.sv]
// byte stream to message assembler with running status.
// assumes bytes come from a receiver on the same clock, one per take.
`timescale 1ns/100ps
`include "mrf_cfg.svh"
module mrf_parser
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// incoming byte, taken when take is high
	input wire logic take,
	input wire mrf_pkg::mrf_byte_t in_byte,
	// complete short message
	output logic msg_valid,
	output mrf_pkg::mrf_byte_t msg_status,
	output mrf_pkg::mrf_byte_t msg_d1,
	output mrf_pkg::mrf_byte_t msg_d2,
	// system exclusive byte stream, start and end included
	output logic sx_valid,
	output mrf_pkg::mrf_byte_t sx_byte,
	output logic in_sysex
);
	import mrf_pkg::*;

	mrf_byte_t run_status;
	mrf_byte_t first_data;
	logic got_one;

	// data bytes that follow a status byte
	function automatic logic [1:0] data_len(input mrf_byte_t st);
		case (st[7:4])
			`MRF_ST_PROG, `MRF_ST_CHAN_AT: data_len = 2'd1;
			`MRF_ST_SYSTEM:
				if (st == `MRF_TIME_CODE || st == `MRF_SONG_SEL)
					data_len = 2'd1;
				else if (st == `MRF_SONG_POS)
					data_len = 2'd2;
				else
					data_len = 2'd0;
			default: data_len = 2'd2;
		endcase
	endfunction

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			run_status <= 8'h00;
			first_data <= 8'h00;
			got_one <= 1'b0;
			in_sysex <= 1'b0;
			msg_valid <= 1'b0;
			msg_status <= 8'h00;
			msg_d1 <= 8'h00;
			msg_d2 <= 8'h00;
			sx_valid <= 1'b0;
			sx_byte <= 8'h00;
		end
		else
		begin
			msg_valid <= 1'b0;
			sx_valid <= 1'b0;
			// realtime bytes are dropped silently, running status kept
			if (take && in_byte < `MRF_REALTIME && in_byte[7])
			begin
				got_one <= 1'b0;
				// any status but a new start closes an open exclusive with an end byte
				if (in_sysex)
				begin
					sx_valid <= 1'b1;
					sx_byte <= `MRF_SX_END;
					in_sysex <= 1'b0;
				end
				if (in_byte == `MRF_SX_START)
				begin
					sx_valid <= 1'b1;
					sx_byte <= `MRF_SX_START;
					in_sysex <= 1'b1;
					run_status <= 8'h00;
				end
				else if (in_byte == `MRF_TUNE_REQ)
				begin
					// lost if it cuts an exclusive short: one output slot
					msg_valid <= !in_sysex;
					msg_status <= in_byte;
					msg_d1 <= 8'h00;
					msg_d2 <= 8'h00;
					run_status <= 8'h00;
				end
				else if (data_len(in_byte) == 2'd0)
					run_status <= 8'h00;
				else
					run_status <= in_byte;
			end
			else if (take && !in_byte[7])
			begin
				if (in_sysex)
				begin
					sx_valid <= 1'b1;
					sx_byte <= in_byte;
				end
				else if (run_status != 8'h00)
				begin
					if (!got_one && data_len(run_status) == 2'd2)
					begin
						first_data <= in_byte;
						got_one <= 1'b1;
					end
					else
					begin
						msg_valid <= 1'b1;
						msg_status <= run_status;
						msg_d1 <= got_one ? first_data : in_byte;
						msg_d2 <= got_one ? in_byte : 8'h00;
						got_one <= 1'b0;
						// system common has no running status
						if (run_status[7:4] == `MRF_ST_SYSTEM)
							run_status <= 8'h00;
					end
				end
			end
		end
	end
endmodule // mrf_parser

// [verilog/mrf_note_map.sv]
// sounding-note table, 16 channels of 128 keys, with a release sweep.
// assumes set, clear and sweep start never come while busy is high.
`timescale 1ns/100ps
`include "mrf_cfg.svh"
module mrf_note_map
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// note tracking
	input wire logic set_en,
	input wire logic clr_en,
	input wire logic [3:0] chan,
	input wire logic [6:0] key,
	// sweep of one channel
	input wire logic sweep_go,
	input wire logic [3:0] sweep_chan,
	output logic busy,
	output logic gen_valid,
	output logic [6:0] gen_key,
	output logic [3:0] gen_chan
);
	logic [127:0] sounding [0:15];
	logic [6:0] idx;

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < 16; i++)
				sounding[i] <= '0;
			idx <= 7'h00;
			busy <= 1'b0;
			gen_valid <= 1'b0;
			gen_key <= 7'h00;
			gen_chan <= 4'h0;
		end
		else
		begin
			gen_valid <= 1'b0;
			if (busy)
			begin
				// one key per cycle: 128 cycles per channel
				gen_valid <= sounding[gen_chan][idx];
				gen_key <= idx;
				sounding[gen_chan][idx] <= 1'b0;
				idx <= idx + 7'd1;
				if (idx == 7'h7f)
					busy <= 1'b0;
			end
			else if (sweep_go)
			begin
				busy <= 1'b1;
				idx <= 7'h00;
				gen_chan <= sweep_chan;
			end
			else if (set_en)
				sounding[chan][key] <= 1'b1;
			else if (clr_en)
				sounding[chan][key] <= 1'b0;
		end
	end
endmodule // mrf_note_map

// [verilog/mrf_record_filter.sv]
// recording-path message filter with an APB register slave.
// assumes incoming bytes on the system clock with valid/ready handshake,
// and a recorder that takes every rec_valid beat.
//
// Summary of operation
// - low nibble of a channel status is the channel, 0 to 15.
// - note-off accepted; note-on with velocity zero counts as note-off.
// - status 9n decodes as note-on with key and velocity.
// - note enable cleared drops note-on and note-off.
// - status An is poly pressure, dropped when its enable is cleared.
// - status Bn with controller 0 to 119 is a control change.
// - control change enable cleared drops control changes.
// - status Cn is program change, dropped when its enable is cleared.
// - status Dn is channel pressure, dropped when its enable is cleared.
// - status En is pitch bend low then high, filtered by its enable.
// - mode enable cleared drops every recordable mode message.
// - controller 121 value zero is reset all, recorded as mode message.
// - omni off or on with value zero: record and release notes.
// - mono with voice count 0 to 16: record and release notes.
// - poly with value zero: record and release notes.
// - tune request recorded only while its enable is set.
// - exclusive from start to end byte recorded when enabled.
// - machine control and time code never reach the recorder.
// - all sound off not recorded but releases notes.
// - local control off or on accepted, never recorded.
// - all notes off not recorded; note-offs for sounding keys recorded.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "mrf_cfg.svh"
module mrf_record_filter
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// incoming midi bytes
	input wire logic in_valid,
	input wire mrf_pkg::mrf_byte_t in_byte,
	output logic in_ready,
	// recorded short messages and exclusive bytes, one beat each
	output logic rec_valid,
	output logic [1:0] rec_len,
	output logic rec_sysex,
	output mrf_pkg::mrf_byte_t rec_status,
	output mrf_pkg::mrf_byte_t rec_data1,
	output mrf_pkg::mrf_byte_t rec_data2
);
	import mrf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic take;
	logic msg_valid;
	mrf_byte_t msg_status;
	mrf_byte_t msg_d1;
	mrf_byte_t msg_d2;
	logic sx_valid;
	mrf_byte_t sx_byte;
	logic in_sysex;
	logic map_busy;
	logic gen_valid;
	logic [6:0] gen_key;
	logic [3:0] gen_chan;
	logic [`MRF_FLT_WIDTH-1:0] filter;
	logic [15:0] local_on;
	logic [31:0] rec_cnt;
	logic [31:0] drop_cnt;
	logic apb_access;
	mrf_sx_state_t sx_state;
	mrf_sx_state_t next_sx_state;
	mrf_byte_t sx_hold [0:3];
	logic [2:0] hold_n;
	logic [2:0] flush_idx;
	logic [2:0] flush_len;
	logic flushing;
	logic start_flush;
	logic keep;
	logic drop;
	logic sweep_go;
	logic note_set;
	logic note_clr;
	logic local_wr;
	logic [1:0] keep_len;
	logic next_rec_valid;
	logic [1:0] next_rec_len;
	logic next_rec_sysex;
	mrf_byte_t next_rec_status;
	mrf_byte_t next_rec_data1;
	mrf_byte_t next_rec_data2;

	// true when the filter bit for a category is set
	function automatic logic enabled(input logic [`MRF_FLT_WIDTH-1:0] f,
		input int pos);
		enabled = f[pos];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// submodules

	assign take = in_valid & in_ready;

	mrf_parser u_parser
	(
		.clock(clock),
		.nrst(nrst),
		.take(take),
		.in_byte(in_byte),
		.msg_valid(msg_valid),
		.msg_status(msg_status),
		.msg_d1(msg_d1),
		.msg_d2(msg_d2),
		.sx_valid(sx_valid),
		.sx_byte(sx_byte),
		.in_sysex(in_sysex)
	);

	mrf_note_map u_note_map
	(
		.clock(clock),
		.nrst(nrst),
		.set_en(note_set),
		.clr_en(note_clr),
		.chan(msg_status[3:0]),
		.key(msg_d1[6:0]),
		.sweep_go(sweep_go),
		.sweep_chan(msg_status[3:0]),
		.busy(map_busy),
		.gen_valid(gen_valid),
		.gen_key(gen_key),
		.gen_chan(gen_chan)
	);

	////////////////////////////////////////////////////////////////////////
	// message classification

	always_comb
	begin
		keep = 1'b0;
		drop = 1'b0;
		sweep_go = 1'b0;
		note_set = 1'b0;
		note_clr = 1'b0;
		local_wr = 1'b0;
		keep_len = 2'd3;
		if (msg_valid)
		begin
			// channel is msg_status[3:0] throughout
			case (msg_status[7:4])
				`MRF_ST_NOTE_OFF:
				begin
					note_clr = 1'b1;
					keep = enabled(filter, `MRF_FLT_NOTE);
				end
				`MRF_ST_NOTE_ON:
				begin
					note_set = msg_d2 != 8'h00;
					note_clr = msg_d2 == 8'h00;
					keep = enabled(filter, `MRF_FLT_NOTE);
				end
				`MRF_ST_POLY_AT:
					keep = enabled(filter, `MRF_FLT_POLY_AT);
				`MRF_ST_CTRL:
				begin
					if (msg_d1 <= `MRF_CC_LAST_PLAIN)
						keep = enabled(filter, `MRF_FLT_CTRL);
					else
						case (msg_d1)
							`MRF_CC_SOUND_OFF:
								sweep_go = msg_d2 == `MRF_VAL_OFF;
							`MRF_CC_RESET_ALL:
								keep = msg_d2 == `MRF_VAL_OFF &&
									enabled(filter, `MRF_FLT_MODE);
							`MRF_CC_LOCAL:
								local_wr = msg_d2 == `MRF_VAL_OFF ||
									msg_d2 == `MRF_VAL_ON;
							`MRF_CC_NOTES_OFF:
								sweep_go = msg_d2 == `MRF_VAL_OFF;
							`MRF_CC_OMNI_OFF, `MRF_CC_OMNI_ON, `MRF_CC_POLY:
							begin
								sweep_go = msg_d2 == `MRF_VAL_OFF;
								keep = sweep_go &&
									enabled(filter, `MRF_FLT_MODE);
							end
							`MRF_CC_MONO:
							begin
								sweep_go = msg_d2 <= `MRF_MONO_MAX;
								keep = sweep_go &&
									enabled(filter, `MRF_FLT_MODE);
							end
							default: keep = 1'b0;
						endcase
				end
				`MRF_ST_PROG:
				begin
					keep = enabled(filter, `MRF_FLT_PROG);
					keep_len = 2'd2;
				end
				`MRF_ST_CHAN_AT:
				begin
					keep = enabled(filter, `MRF_FLT_CHAN_AT);
					keep_len = 2'd2;
				end
				`MRF_ST_BEND:
					keep = enabled(filter, `MRF_FLT_BEND);
				default:
				begin
					// time code and song messages belong to sync
					keep = msg_status == `MRF_TUNE_REQ &&
						enabled(filter, `MRF_FLT_TUNE);
					keep_len = 2'd1;
				end
			endcase
			drop = !keep;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// system exclusive: the first three data bytes are held back so that
	// universal realtime time code and machine control never leak out

	always_comb
	begin
		next_sx_state = sx_state;
		start_flush = 1'b0;
		if (sx_valid)
			case (sx_state)
				MRF_SX_IDLE:
					if (sx_byte == `MRF_SX_START)
						next_sx_state = enabled(filter, `MRF_FLT_SYSEX) ?
							MRF_SX_HOLD : MRF_SX_DROP;
				MRF_SX_HOLD:
					if (sx_byte == `MRF_SX_END)
					begin
						start_flush = 1'b1;
						next_sx_state = MRF_SX_IDLE;
					end
					else if (hold_n == 3'd3)
					begin
						if (sx_hold[1] == `MRF_SX_UNIV_RT &&
							(sx_byte == `MRF_SX_SUB_MTC ||
							sx_byte == `MRF_SX_SUB_MMC))
							next_sx_state = MRF_SX_DROP;
						else
						begin
							start_flush = 1'b1;
							next_sx_state = MRF_SX_PASS;
						end
					end
				MRF_SX_PASS, MRF_SX_DROP:
					if (sx_byte == `MRF_SX_END)
						next_sx_state = MRF_SX_IDLE;
				default: next_sx_state = MRF_SX_IDLE;
			endcase
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			sx_state <= MRF_SX_IDLE;
			hold_n <= 3'd0;
			flushing <= 1'b0;
			flush_idx <= 3'd0;
			flush_len <= 3'd0;
			for (int i = 0; i < 4; i++)
				sx_hold[i] <= 8'h00;
		end
		else
		begin
			sx_state <= next_sx_state;
			if (sx_valid && (sx_state == MRF_SX_IDLE ||
				sx_state == MRF_SX_HOLD))
			begin
				sx_hold[hold_n[1:0]] <= sx_byte;
				hold_n <= sx_state == MRF_SX_IDLE ? 3'd1 : hold_n + 3'd1;
			end
			if (start_flush)
			begin
				flushing <= 1'b1;
				flush_idx <= 3'd0;
				flush_len <= hold_n + 3'd1;
			end
			else if (flushing)
			begin
				flush_idx <= flush_idx + 3'd1;
				if (flush_idx + 3'd1 == flush_len)
					flushing <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// recorder output, input back-pressure

	always_comb
	begin
		next_rec_valid = 1'b0;
		next_rec_len = 2'd1;
		next_rec_sysex = 1'b0;
		next_rec_status = 8'h00;
		next_rec_data1 = 8'h00;
		next_rec_data2 = 8'h00;
		if (gen_valid)
		begin
			// generated note-offs obey the note enable too
			next_rec_valid = enabled(filter, `MRF_FLT_NOTE);
			next_rec_len = 2'd3;
			next_rec_status = {`MRF_ST_NOTE_OFF, gen_chan};
			next_rec_data1 = {1'b0, gen_key};
			next_rec_data2 = `MRF_NOTE_OFF_VEL;
		end
		else if (flushing)
		begin
			next_rec_valid = 1'b1;
			next_rec_sysex = 1'b1;
			next_rec_status = sx_hold[flush_idx[1:0]];
		end
		else if (sx_valid && sx_state == MRF_SX_PASS)
		begin
			next_rec_valid = 1'b1;
			next_rec_sysex = 1'b1;
			next_rec_status = sx_byte;
		end
		else if (keep)
		begin
			next_rec_valid = 1'b1;
			next_rec_len = keep_len;
			next_rec_status = msg_status;
			next_rec_data1 = msg_d1;
			next_rec_data2 = msg_d2;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			rec_valid <= 1'b0;
			rec_len <= 2'd1;
			rec_sysex <= 1'b0;
			rec_status <= 8'h00;
			rec_data1 <= 8'h00;
			rec_data2 <= 8'h00;
		end
		else
		begin
			rec_valid <= next_rec_valid;
			rec_len <= next_rec_len;
			rec_sysex <= next_rec_sysex;
			rec_status <= next_rec_status;
			rec_data1 <= next_rec_data1;
			rec_data2 <= next_rec_data2;
		end
	end

	// a fourth data byte would arrive during a flush, so stall on any work
	always_ff @(posedge clock)
	begin
		if (!nrst)
			in_ready <= 1'b0;
		else
			in_ready <= !take && !msg_valid && !sx_valid && !sweep_go &&
				!map_busy && !start_flush && !flushing;
	end

	////////////////////////////////////////////////////////////////////////
	// state seen by software

	always_ff @(posedge clock)
	begin
		if (!nrst)
			local_on <= `MRF_LOCAL_RESET;
		else if (local_wr)
			local_on[msg_status[3:0]] <= msg_d2[6];
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			rec_cnt <= 32'h0000_0000;
			drop_cnt <= 32'h0000_0000;
		end
		else
		begin
			if (rec_valid)
				rec_cnt <= rec_cnt + 32'd1;
			if (drop)
				drop_cnt <= drop_cnt + 32'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave: ready one cycle into the access phase

	assign apb_access = psel && penable && pready;

	always_ff @(posedge clock)
	begin
		if (!nrst)
			filter <= `MRF_FILTER_RESET;
		else if (apb_access && pwrite && paddr == `MRF_ADDR_FILTER)
			filter <= pwdata[`MRF_FLT_WIDTH-1:0];
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && penable && !pready)
				case (paddr)
					`MRF_ADDR_FILTER:
						prdata <= {23'h000000, filter};
					`MRF_ADDR_STATUS:
						prdata <= {30'h00000000, in_sysex, map_busy};
					`MRF_ADDR_LOCAL:
						prdata <= {16'h0000, local_on};
					`MRF_ADDR_REC_CNT:
						prdata <= rec_cnt;
					`MRF_ADDR_DROP_CNT:
						prdata <= drop_cnt;
					default:
						pslverr <= 1'b1;
				endcase
		end
	end
endmodule // mrf_record_filter

// [bench/mrf_sender.sv]
// far-side sender: an instrument feeding midi bytes over valid/ready.
// assumes the bench fills q and drives slow.
`timescale 1ns/100ps
module mrf_sender
(
	// clock
	input wire logic clock,
	// pacing and handshake
	input wire logic slow,
	input wire logic in_ready,
	output logic in_valid,
	output mrf_pkg::mrf_byte_t in_byte
);
	import mrf_pkg::*;
	mrf_byte_t q[$];
	initial in_valid = 1'b0;
	initial in_byte = 8'h00;
	// a released line shows the inverse so a stale byte never looks valid
	always @(posedge clock)
		if (in_valid && in_ready)
		begin
			in_valid <= 1'b0;
			in_byte <= ~in_byte;
		end
		else if (!in_valid && q.size() != 0 && (!slow || $urandom_range(2) == 0))
		begin
			in_valid <= 1'b1;
			in_byte <= q.pop_front();
		end
endmodule // mrf_sender

// [bench/mrf_record_filter_monitor.sv]
// concurrent checks on the ports of the recording filter.
// assumes the apb master keeps penable high until pready.
`timescale 1ns/100ps
`include "mrf_cfg.svh"
module mrf_record_filter_monitor
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// midi in
	input wire logic in_valid,
	input wire mrf_pkg::mrf_byte_t in_byte,
	input wire logic in_ready,
	// recorder side
	input wire logic rec_valid,
	input wire logic [1:0] rec_len,
	input wire logic rec_sysex,
	input wire mrf_pkg::mrf_byte_t rec_status,
	input wire mrf_pkg::mrf_byte_t rec_data1,
	input wire mrf_pkg::mrf_byte_t rec_data2
);
	import mrf_pkg::*;
	logic [8:0] flt;
	logic beat;
	assign beat = rec_valid && !rec_sysex;
	// shadow of the filter register, updated at the apb completion edge
	always_ff @(posedge clock)
		if (!nrst)
			flt <= `MRF_FILTER_RESET;
		else if (psel && penable && pready && pwrite && paddr == 8'h00)
			flt <= pwdata[8:0];
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////
	a_status_top: assert property (beat |-> rec_status[7]
		&& !rec_data1[7] && !rec_data2[7]) else $error("data bit in status");
	a_note_gate: assert property (beat && rec_status[7:5] == 3'b100
		|-> flt[0] && rec_len == 2'd3) else $error("note beat while off");
	a_poly_gate: assert property (beat && rec_status[7:4] == 4'ha
		|-> flt[1]) else $error("poly pressure beat while off");
	a_ctrl_gate: assert property (beat && rec_status[7:4] == 4'hb
		&& rec_data1 < 8'h78 |-> flt[2]) else $error("control beat while off");
	a_mode_gate: assert property (beat && rec_status[7:4] == 4'hb
		&& rec_data1 >= 8'h78 |-> flt[6] && !(rec_data1 inside {8'h78, 8'h7a,
		8'h7b})) else $error("mode beat wrong");
	a_one_data: assert property (beat && rec_status[7:5] == 3'b110
		|-> rec_len == 2'd2 && rec_data2 == 8'h00 && (rec_status[4] ? flt[4]
		: flt[3])) else $error("one data beat wrong");
	a_bend_gate: assert property (beat && rec_status[7:4] == 4'he
		|-> flt[5]) else $error("bend beat while off");
	a_sync_never: assert property (beat && rec_status[7:4] == 4'hf
		|-> rec_status == 8'hf6 && flt[7]) else $error("system beat wrong");
	a_sysex_gate: assert property (rec_valid && rec_sysex
		|-> flt[8] && rec_len == 2'd1) else $error("sysex beat wrong");
	a_tune_drop: assert property (in_valid && in_ready && in_byte == 8'hf6
		&& !flt[7] |-> ##2 !(rec_valid && rec_status == 8'hf6))
		else $error("tune request recorded while off");
	a_apb_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("apb answer not after one wait");
	a_take_gap: assert property (in_valid && in_ready |=> !in_ready)
		else $error("byte taken too soon");
	a_unmapped: assert property (psel && penable && pready && paddr > 8'h10
		|-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
endmodule // mrf_record_filter_monitor
bind mrf_record_filter mrf_record_filter_monitor u_mon (.clock(clock),
	.nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .in_valid(in_valid), .in_byte(in_byte),
	.in_ready(in_ready), .rec_valid(rec_valid), .rec_len(rec_len),
	.rec_sysex(rec_sysex), .rec_status(rec_status), .rec_data1(rec_data1),
	.rec_data2(rec_data2));

// [bench/test_midi_record_filter.sv]
// self-checking bench of the recording filter against a queue model.
// assumes mrf_sender as the far side and the checker bound in.
`timescale 1ns/100ps
module test_midi_record_filter;
	import mrf_pkg::*;
	logic clock, nrst, psel, penable, pwrite, pready, pslverr, e, slow;
	logic in_valid, in_ready, rec_valid, rec_sysex;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0] rec_len;
	mrf_byte_t in_byte, rec_status, rec_data1, rec_data2;
	logic [26:0] eq[$], got;
	logic [8:0] flt = 9'h1ff;
	logic [15:0] loc = 16'hffff;
	bit snd[16][128];
	int errors, num_checks, nrec, nmsg, nside;
	mrf_record_filter dut (.clock(clock), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready),
		.rec_valid(rec_valid), .rec_len(rec_len), .rec_sysex(rec_sysex),
		.rec_status(rec_status), .rec_data1(rec_data1),
		.rec_data2(rec_data2));
	mrf_sender u_snd (.clock(clock), .slow(slow), .in_ready(in_ready),
		.in_valid(in_valid), .in_byte(in_byte));
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////
	task chk(string w, logic [31:0] x, logic [31:0] g);
		num_checks++;
		if (g !== x)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", w, x, g);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic apb(bit w, logic [7:0] a, logic [31:0] d);
		int t = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
			t++;
		end
		while (pready !== 1'b1 && t < 50);
		chk("pready", 32'h1, {31'h0, pready});
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(logic [7:0] a, logic [31:0] x, logic xe);
		apb(1'b0, a, 32'h0);
		chk($sformatf("read %h", a), x, r);
		chk("pslverr", {31'h0, xe}, {31'h0, e});
	endtask
	task set_f(logic [8:0] v);
		flt = v;
		apb(1'b1, 8'h00, {23'h0, v});
	endtask
	task exp_b(logic [1:0] l, mrf_byte_t s, a, b, logic sx = 1'b0);
		eq.push_back({sx, l, s, a, b});
		nrec++;
	endtask
	task sweep(logic [3:0] c);
		for (int k = 0; k < 128; k++)
			if (snd[c][k])
			begin
				snd[c][k] = 1'b0;
				nside += flt[0];
				if (flt[0]) exp_b(2'd3, {4'h8, c}, 8'(k), 8'h40);
			end
	endtask
	// model of one short message; rs leaves the status to running status
	task msg(mrf_byte_t s, a, b, int n, bit rs = 0);
		logic [3:0] c;
		c = s[3:0];
		nmsg++;
		if (!rs) u_snd.q.push_back(s);
		if (n > 1) u_snd.q.push_back(a);
		if (n > 2) u_snd.q.push_back(b);
		case (s[7:4])
		4'h8, 4'h9:
		begin
			snd[c][a[6:0]] = s[4] && b != 0;
			if (flt[0]) exp_b(2'd3, s, a, b);
		end
		4'ha: if (flt[1]) exp_b(2'd3, s, a, b);
		4'hc, 4'hd: if (s[4] ? flt[4] : flt[3]) exp_b(2'd2, s, a, 8'h00);
		4'he: if (flt[5]) exp_b(2'd3, s, a, b);
		4'hb:
			if (a < 8'h78)
			begin
				if (flt[2]) exp_b(2'd3, s, a, b);
			end
			else if (a == 8'h7a) loc[c] = b[6];
			else if (a == 8'h78 || a == 8'h7b) sweep(c);
			else if (a == 8'h79 || (a == 8'h7e ? b > 8'h10 : b != 0))
			begin
				if (a == 8'h79 && b == 0 && flt[6]) exp_b(2'd3, s, a, b);
			end
			else
			begin
				if (flt[6]) exp_b(2'd3, s, a, b);
				sweep(c);
			end
		4'hf: if (s == 8'hf6 && flt[7]) exp_b(2'd1, s, 8'h00, 8'h00);
		default: ;
		endcase
	endtask
	task sx(logic [47:0] v);
		bit ok;
		ok = flt[8] && !(v[39:32] == 8'h7f && v[23:16] inside {8'h01, 8'h06});
		nside += ok ? 6 : 0;
		for (int i = 5; i >= 0; i--)
		begin
			u_snd.q.push_back(v[i*8 +: 8]);
			if (ok) exp_b(2'd1, v[i*8 +: 8], 8'h00, 8'h00, 1'b1);
		end
	endtask
	task automatic done(string n);
		int t = 0;
		while ((u_snd.q.size() != 0 || in_valid) && t < 9000)
		begin
			@(posedge clock);
			t++;
		end
		chk("drain", 0, u_snd.q.size());
		repeat (4) @(posedge clock);
		t = 0;
		while (in_ready !== 1'b1 && t < 400)
		begin
			@(posedge clock);
			t++;
		end
		chk("in_ready", 32'h1, {31'h0, in_ready});
		repeat (4) @(posedge clock);
		chk("beats left", 0, eq.size());
		eq.delete();
		if (n != "") $display("test %s done", n);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clock)
		if (rec_valid === 1'b1)
		begin
			got = {rec_sysex, rec_len, rec_status, rec_data1, rec_data2};
			if (eq.size() == 0) chk("extra beat", 0, {5'h1f, got});
			else chk("beat", eq.pop_front(), got);
		end
	initial
	begin
		#800000;
		chk("watchdog", 0, 1);
		end_of_test;
	end
	initial
	begin
		logic [7:0] s, a, b;
		int n;
		{nrst, psel, penable, pwrite, slow, paddr, pwdata} = '0;
		void'($urandom(61655));
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		rd(8'h00, 32'h1ff, 1'b0);
		rd(8'h08, 32'hffff, 1'b0);
		rd(8'h14, 32'h0, 1'b1);
		apb(1'b1, 8'h00, 32'hffff_ffff);
		rd(8'h00, 32'h1ff, 1'b0);
		$display("test registers done");
		for (int f = 0; f < 3; f++)
		begin
			set_f(f == 0 ? 9'h1ff : f == 1 ? 9'h0 : 9'($urandom));
			slow = f[0];
			for (int i = 0; i < 16; i++)
			begin
				s = {4'(8 + $urandom_range(6)), 4'($urandom)};
				a = 8'($urandom_range(s[7:4] == 4'hb ? 119 : 127));
				b = $urandom_range(3) == 0 ? 8'h00 : 8'($urandom_range(127));
				n = s[7:5] == 3'b110 ? 2 : 3;
				msg(s, a, b, n);
				msg(s, a ^ 8'h01, b, n, 1);
			end
			done("voice");
		end
		for (int f = 0; f < 3; f++)
		begin
			set_f(f == 0 ? 9'h1ff : f == 1 ? 9'h1bf : 9'h1be);
			for (int m = 8'h78; m < 8'h80; m++)
			begin
				s = {4'hb, 4'($urandom)};
				repeat (3) msg({4'h9, s[3:0]}, 8'($urandom_range(127)),
					8'($urandom_range(127, 1)), 3);
				b = m == 8'h7a ? {1'b0, {7{f[0]}}} : m != 8'h7e ? 8'h00
					: f == 2 ? 8'h11 : 8'($urandom_range(16));
				msg(s, 8'(m), b, 3);
				done("");
				rd(8'h08, {16'h0, loc}, 1'b0);
			end
			$display("test mode done");
		end
		for (int f = 0; f < 2; f++)
		begin
			set_f(f == 0 ? 9'h1ff : 9'h07f);
			msg(8'hf6, 8'h00, 8'h00, 1);
			// 25 is an arbitrary maker id
			sx(48'hf0_25_10_20_30_f7);
			sx(48'hf0_7f_7f_06_01_f7);
			sx(48'hf0_7f_10_01_01_f7);
			msg(8'hf1, 8'h21, 8'h00, 2);
			done("system");
		end
		rd(8'h0c, nrec, 1'b0);
		rd(8'h04, 32'h0, 1'b0);
		rd(8'h10, nmsg - nrec + nside, 1'b0);
		end_of_test;
	end
endmodule // test_midi_record_filter
